// ---- rtl/pmwf_master_write.v ----
// bus-master write sequencer: 64-bit request falling back to a 32-bit two-beat burst
// Summary of operation
// [RULE_01] both strobes in address phase: drive 64-bit data
// [RULE_02] narrow target: devsel without ack64
// [RULE_03] drop req after frame and released wide request
// [RULE_04] narrow answer: clear wide flag, load two
// [RULE_05] devsel and ready last cycle: assert irdy
// [RULE_06] keep frame asserted through the burst
// [RULE_07] phase completes when irdy and trdy asserted
// [RULE_08] decrement beat count after each completed phase
// [RULE_09] second word goes on low lanes
// [RULE_10] ready last cycle keeps irdy asserted
// [RULE_11] final phase next: release frame, keep irdy
`timescale 1ns/1ps
`include "pmwf_consts.vh"
module pmwf_master_write (
	input wire clk_in,
	input wire reset_in,
	input wire local_start_n_in,
	input wire local_wide_request_n_in,
	input wire local_low_word_strobe_n_in,
	input wire local_high_word_strobe_n_in,
	input wire local_master_ready_n_in,
	input wire [31:0] addr_in,
	input wire [3:0] cmd_in,
	input wire [31:0] data1_in,
	input wire [31:0] data2_in,
	input wire [3:0] be1_n_in,
	input wire [3:0] be2_n_in,
	input wire gnt_n_in,
	input wire devsel_n_in,
	input wire trdy_n_in,
	input wire ack64_n_in,
	output reg req_n_out,
	output reg frame_n_out,
	output reg frame_oe_out,
	output reg irdy_n_out,
	output reg irdy_oe_out,
	output reg req64_n_out,
	output reg req64_oe_out,
	output reg [63:0] ad_out,
	output reg ad_oe_out,
	output reg [7:0] cbe_out,
	output reg cbe_oe_out,
	output reg local_bus_grant_n_out,
	output reg local_wide_transfer_flag_n_out,
	output wire [1:0] local_beats_remaining_out,
	output reg done_out
);
	////////////////////////////////////////////////////////////////////////////
	reg [2:0] state_q, state_d;
	reg frame_n_d, irdy_n_d, req_n_d, req64_n_d, wide_n_d, done_d;
	reg frame_oe_d, irdy_oe_d, req64_oe_d, ad_oe_d, cbe_oe_d;
	reg [63:0] ad_d;
	reg [7:0] cbe_d;
	reg devsel_prev_q, ready_prev_q, wide_req_prev_q, both_strobes_q, both_strobes_d;
	reg cnt_load, cnt_dec;
	reg [1:0] cnt_val;
	wire [1:0] beats;
	wire phase_done;
	wire go_ready;

	// beat counter; its register feeds the beat output directly
	pmwf_beat_cnt #(.WIDTH(2)) u_cnt (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.load_in(cnt_load),
		.load_val_in(cnt_val),
		.dec_in(cnt_dec),
		.count_out(beats)
	);
	assign local_beats_remaining_out = beats;

	// a data phase finishes on any rising clock edge with irdy and trdy both low
	assign phase_done = !irdy_n_out && !trdy_n_in; // RULE_07
	// local ready sampled one cycle earlier decides irdy
	assign go_ready = ready_prev_q;

	////////////////////////////////////////////////////////////////////////////
	// history of the previous cycle, active high, plus the active-low local grant
	always @(posedge clk_in) begin
		if (reset_in) begin
			devsel_prev_q <= 1'b0;
			ready_prev_q <= 1'b0;
			wide_req_prev_q <= 1'b0;
			local_bus_grant_n_out <= 1'b1;
		end else begin
			devsel_prev_q <= !devsel_n_in;
			ready_prev_q <= !local_master_ready_n_in;
			wide_req_prev_q <= !local_wide_request_n_in;
			local_bus_grant_n_out <= gnt_n_in; // grant to local side follows the bus grant
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next-state and next-output logic
	always @* begin
		state_d = state_q;
		frame_n_d = frame_n_out;
		irdy_n_d = irdy_n_out;
		req64_n_d = req64_n_out;
		wide_n_d = local_wide_transfer_flag_n_out;
		frame_oe_d = frame_oe_out;
		irdy_oe_d = irdy_oe_out;
		req64_oe_d = req64_oe_out;
		ad_oe_d = ad_oe_out;
		cbe_oe_d = cbe_oe_out;
		ad_d = ad_out;
		cbe_d = cbe_out;
		both_strobes_d = both_strobes_q;
		done_d = 1'b0;
		cnt_load = 1'b0;
		cnt_val = `PMWF_BEATS_WIDE;
		cnt_dec = 1'b0;
		req_n_d = req_n_out;
		// request stays up until the frame has started and the wide request went away
		if (!frame_n_out && !wide_req_prev_q) begin
			req_n_d = 1'b1; // RULE_03
		end
		case (state_q)
			`PMWF_ST_IDLE: begin
				if (!local_start_n_in) begin
					req_n_d = 1'b0;
				end
				if (!req_n_out && !gnt_n_in) begin
					state_d = `PMWF_ST_ADDR;
					frame_n_d = 1'b0;
					req64_n_d = 1'b0;
					wide_n_d = 1'b0;
					frame_oe_d = 1'b1;
					irdy_oe_d = 1'b1;
					req64_oe_d = 1'b1;
					ad_oe_d = 1'b1;
					cbe_oe_d = 1'b1;
					ad_d = {32'h00000000, addr_in};
					cbe_d = {4'hF, cmd_in};
					cnt_load = 1'b1;
					cnt_val = `PMWF_BEATS_WIDE;
				end
			end
			`PMWF_ST_ADDR: begin
				// strobes seen during the address phase pick what goes out next
				both_strobes_d = !local_low_word_strobe_n_in && !local_high_word_strobe_n_in;
				if (both_strobes_d) begin
					ad_d = {data2_in, data1_in}; // RULE_01
					cbe_d = {be2_n_in, be1_n_in}; // RULE_01
				end else begin
					ad_d = {32'h00000000, data1_in};
					cbe_d = {4'hF, be1_n_in};
				end
				state_d = `PMWF_ST_WAIT;
			end
			`PMWF_ST_WAIT: begin
				// narrow answer turns the single wide cycle into a two-beat burst
				if (!devsel_n_in && ack64_n_in && !local_wide_transfer_flag_n_out) begin
					wide_n_d = 1'b1; // RULE_04
					cnt_load = 1'b1; // RULE_04
					cnt_val = `PMWF_BEATS_NARROW; // RULE_04
				end
				if (devsel_prev_q && go_ready) begin
					irdy_n_d = 1'b0; // RULE_05
					// frame held for a burst, released only when one beat remains
					frame_n_d = (beats == `PMWF_BEATS_LAST); // RULE_06
					req64_n_d = frame_n_d;
					state_d = `PMWF_ST_DATA;
				end
			end
			`PMWF_ST_DATA: begin
				if (phase_done && beats == `PMWF_BEATS_LAST) begin
					state_d = `PMWF_ST_TURN;
					irdy_n_d = 1'b1;
					frame_n_d = 1'b1;
					req64_n_d = 1'b1;
					cnt_dec = 1'b1; // RULE_08
					done_d = 1'b1;
				end else if (phase_done) begin
					cnt_dec = 1'b1; // RULE_08
					// target took word one, so word two moves to the low lanes
					ad_d = {32'h00000000, data2_in}; // RULE_09
					cbe_d = {4'hF, be2_n_in}; // RULE_09
					irdy_n_d = !go_ready; // RULE_10
					// final phase next: frame goes high together with irdy low
					frame_n_d = go_ready; // RULE_11
					req64_n_d = 1'b1;
				end else if (irdy_n_out) begin
					// wait state inserted by a slow local master; resume when ready
					irdy_n_d = !go_ready; // RULE_10
					frame_n_d = go_ready && (beats == `PMWF_BEATS_LAST); // RULE_11
				end
			end
			`PMWF_ST_TURN: begin
				// one idle cycle driven high before letting go of the lines
				frame_oe_d = 1'b0;
				irdy_oe_d = 1'b0;
				req64_oe_d = 1'b0;
				ad_oe_d = 1'b0;
				cbe_oe_d = 1'b0;
				state_d = `PMWF_ST_IDLE;
			end
			default: begin
				state_d = `PMWF_ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// output and state registers
	always @(posedge clk_in) begin
		if (reset_in) begin
			state_q <= `PMWF_ST_IDLE;
			req_n_out <= 1'b1;
			frame_n_out <= 1'b1;
			irdy_n_out <= 1'b1;
			req64_n_out <= 1'b1;
			frame_oe_out <= 1'b0;
			irdy_oe_out <= 1'b0;
			req64_oe_out <= 1'b0;
			ad_oe_out <= 1'b0;
			cbe_oe_out <= 1'b0;
			ad_out <= 64'h0000000000000000;
			cbe_out <= 8'hFF;
			local_wide_transfer_flag_n_out <= 1'b1;
			both_strobes_q <= 1'b0;
			done_out <= 1'b0;
		end else begin
			state_q <= state_d;
			req_n_out <= req_n_d;
			frame_n_out <= frame_n_d;
			irdy_n_out <= irdy_n_d;
			req64_n_out <= req64_n_d;
			frame_oe_out <= frame_oe_d;
			irdy_oe_out <= irdy_oe_d;
			req64_oe_out <= req64_oe_d;
			ad_oe_out <= ad_oe_d;
			cbe_oe_out <= cbe_oe_d;
			ad_out <= ad_d;
			cbe_out <= cbe_d;
			local_wide_transfer_flag_n_out <= wide_n_d;
			both_strobes_q <= both_strobes_d;
			done_out <= done_d;
		end
	end
endmodule

// ---- inc/pmwf_consts.vh ----
// constants for the bus-master write sequencer with 32-bit width fallback
`ifndef PMWF_CONSTS_VH
`define PMWF_CONSTS_VH
`define PMWF_ST_IDLE 3'h0
`define PMWF_ST_ADDR 3'h1
`define PMWF_ST_WAIT 3'h2
`define PMWF_ST_DATA 3'h3
`define PMWF_ST_TURN 3'h4
`define PMWF_BEATS_WIDE 2'h1
`define PMWF_BEATS_NARROW 2'h2
`define PMWF_BEATS_LAST 2'h1
`define PMWF_BEATS_RESET 2'h0
`endif

// ---- rtl/pmwf_beat_cnt.v ----
// burst beat counter with load and decrement
`timescale 1ns/1ps
module pmwf_beat_cnt #(
	parameter WIDTH = 2
) (
	input wire clk_in,
	input wire reset_in,
	input wire load_in,
	input wire [WIDTH-1:0] load_val_in,
	input wire dec_in,
	output reg [WIDTH-1:0] count_out
);
	// load wins over decrement; decrement stops at zero so a stray strobe cannot wrap
	always @(posedge clk_in) begin
		if (reset_in) begin
			count_out <= {WIDTH{1'b0}};
		end else if (load_in) begin
			count_out <= load_val_in;
		end else if (dec_in && (count_out != {WIDTH{1'b0}})) begin
			count_out <= count_out - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule

// ---- test/pmwf_checker.sv ----
// port checker for the bus-master write sequencer
`timescale 1ns/1ps
module pmwf_checker (
	input wire clk_in,
	input wire reset_in,
	input wire local_wide_request_n_in,
	input wire local_low_word_strobe_n_in,
	input wire local_high_word_strobe_n_in,
	input wire local_master_ready_n_in,
	input wire [31:0] data1_in,
	input wire [31:0] data2_in,
	input wire [3:0] be1_n_in,
	input wire [3:0] be2_n_in,
	input wire devsel_n_in,
	input wire trdy_n_in,
	input wire ack64_n_in,
	input wire req_n_out,
	input wire frame_n_out,
	input wire irdy_n_out,
	input wire [63:0] ad_out,
	input wire [7:0] cbe_out,
	input wire local_wide_transfer_flag_n_out,
	input wire [1:0] local_beats_remaining_out,
	input wire done_out
);
	// short alias keeps the properties readable
	wire [1:0] b = local_beats_remaining_out;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// a data phase completes on irdy and trdy together
	sequence s_phase;
		!irdy_n_out && !trdy_n_in;
	endsequence
	sequence s_narrow;
		!devsel_n_in && ack64_n_in && !local_wide_transfer_flag_n_out && irdy_n_out;
	endsequence
	a_wide_lanes: assert property ($fell(frame_n_out) && !local_low_word_strobe_n_in
		&& !local_high_word_strobe_n_in |=> ad_out == {data2_in, data1_in}
		&& cbe_out == {be2_n_in, be1_n_in}) else $error("wide lanes wrong");
	a_req_drop: assert property (!frame_n_out && $past(local_wide_request_n_in)
		|=> req_n_out) else $error("request kept");
	a_narrow_load: assert property (s_narrow |=> local_wide_transfer_flag_n_out
		&& b == 2'h2) else $error("fallback load wrong");
	a_irdy_start: assert property (!devsel_n_in && !local_master_ready_n_in && b == 2'h2
		&& irdy_n_out |-> ##[1:2] !irdy_n_out) else $error("irdy late");
	a_irdy_keep: assert property (s_phase and (b == 2'h2 && !$past(local_master_ready_n_in))
		|=> !irdy_n_out) else $error("irdy dropped with ready");
	a_frame_held: assert property (!irdy_n_out && b == 2'h2 |-> !frame_n_out)
		else $error("frame released early");
	a_beat_dec: assert property (s_phase and b == 2'h2 |=> b == 2'h1)
		else $error("count not decremented");
	a_low_lanes: assert property (s_phase and b == 2'h2 |=> ad_out[31:0] == data2_in
		&& cbe_out[3:0] == be2_n_in) else $error("second word lanes wrong");
	a_last_frame: assert property (!irdy_n_out && b == 2'h1 |-> frame_n_out)
		else $error("frame held on last phase");
	a_turn_done: assert property (s_phase and b == 2'h1 |=> irdy_n_out && done_out
		&& b == 2'h0) else $error("end of burst wrong");
endmodule
bind pmwf_master_write pmwf_checker u_pmwf_checker (
	.clk_in(clk_in),
	.reset_in(reset_in),
	.local_wide_request_n_in(local_wide_request_n_in),
	.local_low_word_strobe_n_in(local_low_word_strobe_n_in),
	.local_high_word_strobe_n_in(local_high_word_strobe_n_in),
	.local_master_ready_n_in(local_master_ready_n_in),
	.data1_in(data1_in),
	.data2_in(data2_in),
	.be1_n_in(be1_n_in),
	.be2_n_in(be2_n_in),
	.devsel_n_in(devsel_n_in),
	.trdy_n_in(trdy_n_in),
	.ack64_n_in(ack64_n_in),
	.req_n_out(req_n_out),
	.frame_n_out(frame_n_out),
	.irdy_n_out(irdy_n_out),
	.ad_out(ad_out),
	.cbe_out(cbe_out),
	.local_wide_transfer_flag_n_out(local_wide_transfer_flag_n_out),
	.local_beats_remaining_out(local_beats_remaining_out),
	.done_out(done_out)
);

// ---- test/pmwf_target.sv ----
// behavioural bus target, narrow or wide, with optional trdy wait states
`timescale 1ns/1ps
module pmwf_target (
	input wire clk_in,
	input wire frame_n_in,
	input wire irdy_n_in,
	input wire narrow_in,
	input wire [1:0] slow_in,
	output reg devsel_n_out,
	output reg trdy_n_out,
	output reg ack64_n_out
);
	reg [3:0] w_q = 4'h0;
	reg [3:0] w_d;
	initial {devsel_n_out, trdy_n_out, ack64_n_out} = 3'h7;
	// waits count irdy-low cycles since the last completed phase, so every phase gets them
	always @* begin
		if (!irdy_n_in && !trdy_n_out) begin
			w_d = 4'h0;
		end else if (!irdy_n_in) begin
			w_d = w_q + 4'h1;
		end else begin
			w_d = w_q;
		end
	end
	// claim while frame or irdy is low; released lines fall back to the pull-up
	always @(posedge clk_in) begin
		if (!frame_n_in || !irdy_n_in) begin
			devsel_n_out <= 1'b0;
			ack64_n_out <= narrow_in;
			trdy_n_out <= (w_d < {2'h0, slow_in});
			w_q <= w_d;
		end else begin
			{devsel_n_out, trdy_n_out, ack64_n_out} <= 3'h7;
			w_q <= 4'h0;
		end
	end
endmodule

// ---- test/tb.sv ----
// testbench: narrow and wide targets, trdy and ready wait states
`timescale 1ns/1ps
module tb;
	reg clk_in = 0, reset_in = 1, st_n = 1, rdy_n = 0, gnt_n = 1, narrow = 0;
	reg wr_n = 1, ls_n = 0, hs_n = 0;
	reg [31:0] d1 = 0, d2 = 0, a = 0, r = 0;
	reg [3:0] b1 = 0, b2 = 0, cmd = 0;
	reg [1:0] slow = 0;
	wire req_n, frame_n, irdy_n, devsel_n, trdy_n, ack64_n, done;
	wire fr_oe, ir_oe, r64_oe, ad_oe, cbe_oe, req64_n, lgnt_n, wide_n;
	wire [1:0] beats;
	wire [63:0] ad;
	wire [7:0] cbe;
	integer err_total = 0, tests_run = 0, seed = 32'h09b11e1f, i, k;
	reg [71:0] q[$];
	always #20 clk_in = ~clk_in;
	pmwf_master_write u_pmwf_master_write (.clk_in(clk_in), .reset_in(reset_in),
		.local_start_n_in(st_n), .local_wide_request_n_in(wr_n),
		.local_low_word_strobe_n_in(ls_n), .local_high_word_strobe_n_in(hs_n),
		.local_master_ready_n_in(rdy_n), .addr_in(a), .cmd_in(cmd), .data1_in(d1),
		.data2_in(d2), .be1_n_in(b1), .be2_n_in(b2), .gnt_n_in(gnt_n),
		.devsel_n_in(devsel_n), .trdy_n_in(trdy_n), .ack64_n_in(ack64_n),
		.req_n_out(req_n), .frame_n_out(frame_n), .frame_oe_out(fr_oe), .irdy_n_out(irdy_n),
		.irdy_oe_out(ir_oe), .req64_n_out(req64_n), .req64_oe_out(r64_oe), .ad_out(ad),
		.ad_oe_out(ad_oe), .cbe_out(cbe), .cbe_oe_out(cbe_oe), .local_bus_grant_n_out(lgnt_n),
		.local_wide_transfer_flag_n_out(wide_n), .local_beats_remaining_out(beats),
		.done_out(done));
	pmwf_target u_pmwf_target (.clk_in(clk_in), .frame_n_in(frame_n), .irdy_n_in(irdy_n),
		.narrow_in(narrow), .slow_in(slow), .devsel_n_out(devsel_n), .trdy_n_out(trdy_n),
		.ack64_n_out(ack64_n));
	task check(input string nm, input [71:0] s, input [71:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0s exp %h seen %h", nm, e, s);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// the arbiter grants whatever is requested
	always @(negedge clk_in) gnt_n <= req_n;
	// each completing phase takes the oldest expected lane value, sampled mid-cycle
	always @(negedge clk_in) if (!reset_in && !irdy_n && !trdy_n) begin
		if (q.size() == 0) check("extra", 1, 0);
		else check("lanes", {cbe, ad}, q.pop_front());
	end
	initial begin
		repeat (5) @(negedge clk_in);
		reset_in = 0;
		// narrow held wide request, wide, narrow trdy waits, narrow random ready, one strobe
		for (i = 0; i < 5; i++) begin
			narrow = (i != 1 && i != 4);
			slow = (i == 2) ? 2'h2 : 2'h0;
			rdy_n = (i == 3);
			wr_n = (i != 0);
			d1 = $random(seed);
			d2 = $random(seed);
			a = $random(seed);
			r = $random(seed);
			{b1, b2, cmd} = r[11:0];
			ls_n = (i == 4) && r[12];
			hs_n = (i == 4) && !r[12];
			if (i == 4) q.push_back({4'hF, b1, 32'h0, d1});
			else q.push_back({b2, b1, d2, d1});
			if (narrow) q.push_back({4'hF, b2, 32'h0, d2});
			st_n = 0;
			k = 0;
			while (frame_n !== 1'b0 && k < 20) begin
				@(negedge clk_in);
				k++;
			end
			st_n = 1;
			// a wide request held through the address phase keeps req one cycle longer
			wr_n = 1;
			@(negedge clk_in);
			check("req", req_n, i != 0);
			check("grant", lgnt_n, gnt_n);
			k = 0;
			while (done !== 1'b1 && k < 40) begin
				@(negedge clk_in);
				r = $random(seed);
				if (i == 3) rdy_n = r[0];
				k++;
			end
			rdy_n = 0;
			check("done", done, 1);
			check("beats", beats, 2'h0);
			check("left", q.size(), 0);
			check("wide flag", wide_n, narrow);
			check("drive", {fr_oe, ir_oe, r64_oe, ad_oe, cbe_oe, req64_n}, 6'h3F);
			@(negedge clk_in);
			check("release", {fr_oe, ir_oe, r64_oe, ad_oe, cbe_oe}, 5'h00);
			$display("test %0d finished", i);
			@(negedge clk_in);
		end
		results;
	end
	// five transfers need well under 200 cycles; a hang past 500 counts as a failure
	initial begin
		#20000;
		err_total++;
		results;
	end
endmodule
